/* File: rtl/path_overhead_pkg.sv */
// constants for the path overhead control block: register map, fields,
// reset values and line-side byte classes.
// assumes one 50 MHz clock and a classic wishbone port with 32-bit data.
package path_overhead_pkg;

  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_MASTER        = 7'h00;
  localparam logic [6:0] IDX_EVENT_STATUS  = 7'h31;
  localparam logic [6:0] IDX_PARITY_LO     = 7'h38;
  localparam logic [6:0] IDX_PARITY_HI     = 7'h39;
  localparam logic [6:0] IDX_FAR_LO        = 7'h3a;
  localparam logic [6:0] IDX_FAR_HI        = 7'h3b;
  localparam logic [6:0] IDX_PARITY_CFG    = 7'h3d;
  localparam logic [6:0] IDX_TX_DIAG       = 7'h40;
  localparam logic [6:0] IDX_TX_PTR_CTL    = 7'h41;
  localparam logic [6:0] IDX_ARBITRARY_POINTER_VALUE_LO       = 7'h45;
  localparam logic [6:0] IDX_ARBITRARY_POINTER_VALUE_HI       = 7'h46;

  // master register
  localparam int FIXED_PTR_BIT = 0;
  // event status register
  localparam int PARITY_EVT_BIT = 1;
  localparam int FAR_EVT_BIT    = 0;
  // parity configuration
  localparam int BLOCK_PARITY_BIT = 5;
  localparam logic [7:0] PARITY_CFG_MASK  = 8'hf7;
  localparam logic [7:0] PARITY_CFG_RESET = 8'h00;
  // transmit diagnostic control
  localparam int ALARM_INSERT_BIT  = 0;
  localparam int PARITY_INVERT_BIT = 1;
  localparam logic [2:0] TX_DIAG_RESET = 3'h0;
  // transmit pointer control
  localparam int POS_JUST_BIT    = 1;
  localparam int NEG_JUST_BIT    = 2;
  localparam int NDF_FORCE_BIT   = 3;
  localparam int PTR_LOAD_BIT    = 4;
  localparam int SPACING_BIT     = 5;
  localparam int FORCED_PTR_BIT  = 6;
  localparam logic [6:0] PTR_CTL_RESET = 7'h00;
  // arbitrary pointer upper register fields
  localparam int NDF_PAT_LSB  = 4;
  localparam int SS_LSB       = 2;
  localparam logic [7:0] ARBITRARY_POINTER_VALUE_LO_RESET = 8'h00;
  localparam logic [7:0] ARBITRARY_POINTER_VALUE_HI_RESET = 8'h90;

  // payload pointer
  localparam logic [9:0] PTR_MAX      = 10'd782;
  localparam logic [3:0] NDF_NORMAL   = 4'b0110;
  localparam logic [9:0] INC_BIT_MASK = 10'h2aa;
  localparam logic [9:0] DEC_BIT_MASK = 10'h155;
  localparam logic [1:0] SPACING_FRAMES = 2'd3;
  localparam logic [3:0] FAR_ERR_MAX  = 4'd8;

  // line-side byte classes on TX_BYTE_CLASS
  localparam logic [2:0] CLS_OTHER = 3'd0;
  localparam logic [2:0] CLS_SPE   = 3'd1;
  localparam logic [2:0] CLS_H1    = 3'd2;
  localparam logic [2:0] CLS_H2    = 3'd3;
  localparam logic [2:0] CLS_H3    = 3'd4;
  localparam logic [2:0] CLS_B3    = 3'd5;

endpackage : path_overhead_pkg

/* File: rtl/path_overhead_ctrl.sv */
// path overhead control: receive path error counters and transmit path
// pointer, alarm and parity insertion, with a classic wishbone slave.
// assumes line-side strobes are synchronous to REF_CLK; one frame start
// pulse arrives before the H1 byte of each transmitted frame.
`timescale 1ns/100ps

// Overview of operation
// - count received path parity errors; polled count in two byte registers.
// - any path counter write captures both counters and restarts from zero.
// - an error in the poll cycle lands in the captured value.
// - a write to the master register also captures and clears both counters.
// - count far-end block errors from G1 likewise in a second counter.
// - block parity mode counts and reports at most one error per frame.
// - bit mode counts every mismatching parity bit, up to eight per frame.
// - alarm insert forces SPE, H1, H2, H3 and B3 bytes to all ones.
// - parity invert control sends the inverse of the computed B3 byte.
// - rising positive request gives one positive justification, self-clears.
// - rising negative request gives one negative justification, self-clears.
// - fixed pointer setting ignores justify, load and forced pointer.
// - flag control inserts programmed pattern continuously, as does a successful pointer load for its frame, else 0110.
// - pointer load moves pointer to programmed value if not above 782.
// - pointer load bit clears itself at the next frame start, even for a value above 782.
// - spacing bit limits justifications to one in any four frames.
// - forced pointer sends arbitrary value in H1, H2, at least one frame.
// - event flags set on errors and clear when their status is read.
// - flag pattern comes from the arbitrary pointer upper register.
module path_overhead_ctrl
  import path_overhead_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [31:0] ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // receive path results, one pulse per frame each
  input  wire logic        RX_B3_VALID,
  input  wire logic [7:0]  RX_B3_MISMATCH,
  input  wire logic        RX_G1_VALID,
  input  wire logic [3:0]  RX_G1_FAR_ERR,
  // parity errors per frame handed to the transmit path
  output logic             TX_FAR_REPORT_VALID,
  output logic      [3:0]  TX_FAR_REPORT,
  // transmit stream
  input  wire logic        TX_FRAME_START,
  input  wire logic        TX_BYTE_VALID,
  input  wire logic [2:0]  TX_BYTE_CLASS,
  input  wire logic [7:0]  TX_BYTE_IN,
  output logic             TX_BYTE_OUT_VALID,
  output logic      [7:0]  TX_BYTE_OUT,
  output logic      [9:0]  TX_POINTER,
  output logic             TX_JUST_POS,
  output logic             TX_JUST_NEG
);

  //////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [6:0]  idx;
  logic        mapped_space;
  logic        req;
  logic        wr;
  logic        rd;
  logic        ack_q;
  assign idx          = ADR_I[8:2];
  assign mapped_space = (ADR_I[31:9] == 23'h0) && (ADR_I[1:0] == 2'b00);
  assign req          = CYC_I && STB_I && !ack_q;
  assign wr           = req && WE_I && SEL_I[0] && mapped_space;
  assign rd           = req && !WE_I && mapped_space;
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  assign ACK_O = ack_q;
  //////////////////////////////////////////////////////////////////////////
  // control registers
  logic       fixed_ptr_q;
  logic [7:0] parity_cfg_q;
  logic [2:0] tx_diag_q;
  logic [6:0] ptr_ctl_q;
  logic [6:0] ptr_ctl_d;
  logic [7:0] arbitrary_pointer_value_lo_q;
  logic [7:0] arbitrary_pointer_value_hi_q;
  logic       force_owed_q;
  logic       pos_done;
  logic       neg_done;
  logic       load_done;
  logic       wr_ptr_ctl;
  logic [9:0] arbitrary_pointer_value;
  logic [3:0] ndf_pattern;
  assign wr_ptr_ctl  = wr && (idx == IDX_TX_PTR_CTL);
  assign arbitrary_pointer_value        = {arbitrary_pointer_value_hi_q[1:0], arbitrary_pointer_value_lo_q};
  assign ndf_pattern = arbitrary_pointer_value_hi_q[NDF_PAT_LSB +: 4];
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fixed_ptr_q  <= 1'b0;
      parity_cfg_q <= PARITY_CFG_RESET;
      tx_diag_q    <= TX_DIAG_RESET;
      arbitrary_pointer_value_lo_q    <= ARBITRARY_POINTER_VALUE_LO_RESET;
      arbitrary_pointer_value_hi_q    <= ARBITRARY_POINTER_VALUE_HI_RESET;
    end else if (wr) begin
      unique case (idx)
        IDX_MASTER:     fixed_ptr_q  <= DAT_I[FIXED_PTR_BIT];
        IDX_PARITY_CFG: parity_cfg_q <= DAT_I[7:0] & PARITY_CFG_MASK;
        IDX_TX_DIAG:    tx_diag_q    <= DAT_I[2:0];
        IDX_ARBITRARY_POINTER_VALUE_LO:    arbitrary_pointer_value_lo_q    <= DAT_I[7:0];
        IDX_ARBITRARY_POINTER_VALUE_HI:    arbitrary_pointer_value_hi_q    <= DAT_I[7:0];
        default: ;
      endcase
    end
  end

  // request bits self-clear when serviced; a done only happens while the
  // bit is one, so a fresh write of one is never lost
  always_comb begin
    ptr_ctl_d = wr_ptr_ctl ? DAT_I[6:0] : ptr_ctl_q;
    if (pos_done) begin
      ptr_ctl_d[POS_JUST_BIT] = 1'b0;
    end
    if (neg_done) begin
      ptr_ctl_d[NEG_JUST_BIT] = 1'b0;
    end
    if (load_done) begin
      ptr_ctl_d[PTR_LOAD_BIT] = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_ctl_q <= PTR_CTL_RESET;
    end else begin
      ptr_ctl_q <= ptr_ctl_d;
    end
  end

  // a rising forced-pointer bit owes at least one corrupted frame
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      force_owed_q <= 1'b0;
    end else if (wr_ptr_ctl && DAT_I[FORCED_PTR_BIT]
                 && !ptr_ctl_q[FORCED_PTR_BIT]) begin
      force_owed_q <= 1'b1;
    end else if (TX_FRAME_START) begin
      force_owed_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive error accumulation
  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic [3:0]  b);
    logic [16:0] sum;
    sum = {1'b0, a} + {13'h0, b};
    return sum[16] ? 16'hffff : sum[15:0];
  endfunction : sat_add
  logic [3:0]  bit_errs;
  logic [3:0]  parity_inc;
  logic [3:0]  far_inc;
  logic        poll;
  logic [15:0] parity_acc_q;
  logic [15:0] parity_hold_q;
  logic [15:0] far_acc_q;
  logic [15:0] far_hold_q;
  logic [1:0]  event_q;
  logic        rd_status;
  always_comb begin
    bit_errs = 4'h0;
    for (int i = 0; i < 8; i++) begin
      bit_errs = bit_errs + {3'h0, RX_B3_MISMATCH[i]};
    end
  end

  always_comb begin
    parity_inc = 4'h0;
    if (RX_B3_VALID) begin
      if (parity_cfg_q[BLOCK_PARITY_BIT]) begin
        parity_inc = {3'h0, |RX_B3_MISMATCH};
      end else begin
        parity_inc = bit_errs;
      end
    end
  end

  // values above eight carry no error count
  assign far_inc = (RX_G1_VALID && RX_G1_FAR_ERR <= FAR_ERR_MAX)
                   ? RX_G1_FAR_ERR : 4'h0;

  assign poll = wr && ((idx == IDX_MASTER)
                || (idx >= IDX_PARITY_LO && idx <= IDX_FAR_HI));

  // the poll cycle's own increment goes into the captured value
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      parity_acc_q  <= 16'h0;
      parity_hold_q <= 16'h0;
      far_acc_q     <= 16'h0;
      far_hold_q    <= 16'h0;
    end else if (poll) begin
      parity_hold_q <= sat_add(parity_acc_q, parity_inc);
      far_hold_q    <= sat_add(far_acc_q, far_inc);
      parity_acc_q  <= 16'h0;
      far_acc_q     <= 16'h0;
    end else begin
      parity_acc_q <= sat_add(parity_acc_q, parity_inc);
      far_acc_q    <= sat_add(far_acc_q, far_inc);
    end
  end

  assign rd_status = rd && (idx == IDX_EVENT_STATUS);
  // set wins over the clear by read
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      event_q <= 2'b00;
    end else begin
      event_q[PARITY_EVT_BIT] <= (parity_inc != 4'h0)
        || (event_q[PARITY_EVT_BIT] && !rd_status);
      event_q[FAR_EVT_BIT]    <= (far_inc != 4'h0)
        || (event_q[FAR_EVT_BIT] && !rd_status);
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      TX_FAR_REPORT_VALID <= 1'b0;
      TX_FAR_REPORT       <= 4'h0;
    end else begin
      TX_FAR_REPORT_VALID <= RX_B3_VALID;
      if (RX_B3_VALID) begin
        TX_FAR_REPORT <= parity_inc;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit pointer generation, decided once per frame
  logic       act_ok;
  logic       space_ok;
  logic       do_load;
  logic       load_ok;
  logic       do_pos;
  logic       do_neg;
  logic [9:0] ptr_q;
  logic [9:0] ptr_base;
  logic       just_pos_q;
  logic       just_neg_q;
  logic       ndf_frame_q;
  logic       force_frame_q;
  logic [1:0] space_cnt_q;
  assign act_ok   = !fixed_ptr_q;
  assign space_ok = !ptr_ctl_q[SPACING_BIT]
                    || (space_cnt_q == SPACING_FRAMES);
  assign do_load  = act_ok && ptr_ctl_q[PTR_LOAD_BIT];
  assign load_ok  = do_load && (arbitrary_pointer_value <= PTR_MAX);
  assign do_pos   = act_ok && !do_load && space_ok
                    && ptr_ctl_q[POS_JUST_BIT];
  assign do_neg   = act_ok && !do_load && space_ok
                    && !ptr_ctl_q[POS_JUST_BIT]
                    && ptr_ctl_q[NEG_JUST_BIT];

  assign pos_done  = TX_FRAME_START && do_pos;
  assign neg_done  = TX_FRAME_START && do_neg;
  assign load_done = TX_FRAME_START && do_load;
  // last frame's justification moves the pointer for this frame
  always_comb begin
    ptr_base = ptr_q;
    if (just_pos_q) begin
      ptr_base = (ptr_q == PTR_MAX) ? 10'h0 : ptr_q + 10'h1;
    end else if (just_neg_q) begin
      ptr_base = (ptr_q == 10'h0) ? PTR_MAX : ptr_q - 10'h1;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_q         <= 10'h0;
      just_pos_q    <= 1'b0;
      just_neg_q    <= 1'b0;
      ndf_frame_q   <= 1'b0;
      force_frame_q <= 1'b0;
      space_cnt_q   <= SPACING_FRAMES;
    end else if (TX_FRAME_START) begin
      ptr_q         <= load_ok ? arbitrary_pointer_value : ptr_base;
      just_pos_q    <= do_pos;
      just_neg_q    <= do_neg;
      ndf_frame_q   <= ptr_ctl_q[NDF_FORCE_BIT] || load_ok;
      force_frame_q <= act_ok && (ptr_ctl_q[FORCED_PTR_BIT]
                                  || force_owed_q);
      if (do_pos || do_neg) begin
        space_cnt_q <= 2'd0;
      end else if (space_cnt_q != SPACING_FRAMES) begin
        space_cnt_q <= space_cnt_q + 2'd1;
      end
    end
  end

  assign TX_POINTER  = ptr_q;
  assign TX_JUST_POS = just_pos_q;
  assign TX_JUST_NEG = just_neg_q;
  //////////////////////////////////////////////////////////////////////////
  // transmit byte overwrite
  logic [9:0]  ptr_sent;
  logic [9:0]  ptr_flip;
  logic [15:0] ptr_word;
  logic        alarm_byte;
  logic [7:0]  byte_d;
  assign ptr_sent = force_frame_q ? arbitrary_pointer_value : ptr_q;
  assign ptr_flip = just_pos_q ? INC_BIT_MASK
                  : (just_neg_q ? DEC_BIT_MASK : 10'h0);
  assign ptr_word = {(ndf_frame_q ? ndf_pattern : NDF_NORMAL),
                     arbitrary_pointer_value_hi_q[SS_LSB +: 2], ptr_sent ^ ptr_flip};

  assign alarm_byte = tx_diag_q[ALARM_INSERT_BIT]
                      && (TX_BYTE_CLASS != CLS_OTHER);

  always_comb begin
    byte_d = TX_BYTE_IN;
    if (alarm_byte) begin
      byte_d = 8'hff;
    end else if (TX_BYTE_CLASS == CLS_H1) begin
      byte_d = ptr_word[15:8];
    end else if (TX_BYTE_CLASS == CLS_H2) begin
      byte_d = ptr_word[7:0];
    end else if (TX_BYTE_CLASS == CLS_B3
                 && tx_diag_q[PARITY_INVERT_BIT]) begin
      byte_d = ~TX_BYTE_IN;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      TX_BYTE_OUT_VALID <= 1'b0;
      TX_BYTE_OUT       <= 8'h0;
    end else begin
      TX_BYTE_OUT_VALID <= TX_BYTE_VALID;
      if (TX_BYTE_VALID) begin
        TX_BYTE_OUT <= byte_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h0;
    unique case (idx)
      IDX_MASTER:       rd_byte = {7'h0, fixed_ptr_q};
      IDX_EVENT_STATUS: rd_byte = {6'h0, event_q};
      IDX_PARITY_LO:    rd_byte = parity_hold_q[7:0];
      IDX_PARITY_HI:    rd_byte = parity_hold_q[15:8];
      IDX_FAR_LO:       rd_byte = far_hold_q[7:0];
      IDX_FAR_HI:       rd_byte = far_hold_q[15:8];
      IDX_PARITY_CFG:   rd_byte = parity_cfg_q;
      IDX_TX_DIAG:      rd_byte = {5'h0, tx_diag_q};
      IDX_TX_PTR_CTL:   rd_byte = {1'b0, ptr_ctl_q};
      IDX_ARBITRARY_POINTER_VALUE_LO:      rd_byte = arbitrary_pointer_value_lo_q;
      IDX_ARBITRARY_POINTER_VALUE_HI:      rd_byte = arbitrary_pointer_value_hi_q;
      default:          rd_byte = 8'h0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      DAT_O <= 32'h0;
    end else if (req) begin
      DAT_O <= rd ? {24'h0, rd_byte} : 32'h0;
    end
  end

endmodule : path_overhead_ctrl

/* File: testbench/path_overhead_ctrl_properties.sv */
// checker on the top ports of the path overhead control block.
// assumes requests held until ACK_O, as classic wishbone asks.
`timescale 1ns/100ps
module path_overhead_ctrl_properties
  import path_overhead_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        RX_B3_VALID,
  input wire logic        TX_FAR_REPORT_VALID,
  input wire logic [3:0]  TX_FAR_REPORT,
  input wire logic        TX_FRAME_START,
  input wire logic        TX_BYTE_VALID,
  input wire logic        TX_BYTE_OUT_VALID,
  input wire logic [9:0]  TX_POINTER,
  input wire logic        TX_JUST_POS,
  input wire logic        TX_JUST_NEG
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////////
  ack_latency_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  read_width_a: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
    else $error("upper read data not zero");
  report_delay_a: assert property (RX_B3_VALID |=>
    TX_FAR_REPORT_VALID && TX_FAR_REPORT <= FAR_ERR_MAX)
    else $error("parity report missing or too large");
  report_cause_a: assert property (TX_FAR_REPORT_VALID |->
    $past(RX_B3_VALID))
    else $error("parity report without a frame result");
  byte_delay_a: assert property (TX_BYTE_OUT_VALID ==
    $past(TX_BYTE_VALID))
    else $error("output byte not one cycle after input");
  just_excl_a: assert property (!(TX_JUST_POS && TX_JUST_NEG))
    else $error("both justifications at once");
  just_hold_a: assert property (!TX_FRAME_START |=>
    $stable({TX_JUST_POS, TX_JUST_NEG}))
    else $error("justification changed inside a frame");
  ptr_range_a: assert property (TX_POINTER <= PTR_MAX)
    else $error("pointer above the legal range");
  ptr_hold_a: assert property (!TX_FRAME_START |=> $stable(TX_POINTER))
    else $error("pointer changed inside a frame");
  cover property (ACK_O);
  cover property (TX_JUST_POS);
  cover property (TX_JUST_NEG);
  cover property (TX_FAR_REPORT_VALID && TX_FAR_REPORT == 4'd2);
endmodule : path_overhead_ctrl_properties

bind path_overhead_ctrl path_overhead_ctrl_properties u_props (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .CYC_I(CYC_I), .STB_I(STB_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .RX_B3_VALID(RX_B3_VALID),
  .TX_FAR_REPORT_VALID(TX_FAR_REPORT_VALID), .TX_FAR_REPORT(TX_FAR_REPORT),
  .TX_FRAME_START(TX_FRAME_START), .TX_BYTE_VALID(TX_BYTE_VALID),
  .TX_BYTE_OUT_VALID(TX_BYTE_OUT_VALID), .TX_POINTER(TX_POINTER),
  .TX_JUST_POS(TX_JUST_POS), .TX_JUST_NEG(TX_JUST_NEG));

/* File: testbench/line_stream_model.sv */
// line side model: frame results on receive, one short frame on transmit.
// assumes the caller runs one task at a time per direction.
`timescale 1ns/100ps
module line_stream_model
  import path_overhead_pkg::*;
(
  input  wire logic       clk,
  output logic            frame_start,
  output logic            byte_valid,
  output logic [2:0]      byte_class,
  output logic [7:0]      byte_in,
  input  wire logic [7:0] byte_out,
  output logic            b3_valid,
  output logic [7:0]      b3_mismatch,
  output logic            g1_valid,
  output logic [3:0]      g1_far
);
  initial begin
    frame_start = 1'b0;
    byte_valid  = 1'b0;
    byte_class  = CLS_OTHER;
    byte_in     = 8'h00;
    b3_valid    = 1'b0;
    b3_mismatch = 8'h00;
    g1_valid    = 1'b0;
    g1_far      = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one frame result; idle data lines show the inverse value
  task automatic rx(input logic b, input logic [7:0] m, input logic g,
                    input logic [3:0] f);
    @(posedge clk);
    b3_valid    <= b;
    b3_mismatch <= m;
    g1_valid    <= g;
    g1_far      <= f;
    @(posedge clk);
    b3_valid    <= 1'b0;
    g1_valid    <= 1'b0;
    b3_mismatch <= ~m;
    g1_far      <= ~f;
    #1;
  endtask : rx
  // got holds H1, H2, H3, SPE, B3 from high byte down
  task automatic send_frame(output logic [39:0] got);
    logic [14:0] seq;
    seq = {CLS_H1, CLS_H2, CLS_H3, CLS_SPE, CLS_B3};
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      byte_valid <= 1'b1;
      byte_class <= seq[14-3*i -: 3];
      byte_in    <= 8'h50 + 8'(i);
      @(posedge clk);
      byte_valid <= 1'b0;
      byte_in    <= ~byte_in;
      #1 got[39-8*i -: 8] = byte_out;
    end
  endtask : send_frame
endmodule : line_stream_model

/* File: testbench/tb.sv */
// bench for the path overhead control block with the line stream model.
// assumes one 50 MHz clock; register access over classic wishbone.
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import path_overhead_pkg::*;
  logic        ref_clk, rst_b, cyc, stb, we, ack, b3_v, g1_v, rep_v;
  logic        fs, bv, bov, jpos, jneg;
  logic [31:0] adr, dat_w, dat_r;
  logic [3:0]  sel, g1_f, rep;
  logic [7:0]  b3_m, bin, bout;
  logic [2:0]  bcls;
  logic [9:0]  ptr;
  logic [39:0] g;
  int          n_errors, checks, cycles;

  path_overhead_ctrl u_path_overhead_ctrl (
    .REF_CLK(ref_clk), .RST_B(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .RX_B3_VALID(b3_v), .RX_B3_MISMATCH(b3_m), .RX_G1_VALID(g1_v),
    .RX_G1_FAR_ERR(g1_f), .TX_FAR_REPORT_VALID(rep_v), .TX_FAR_REPORT(rep),
    .TX_FRAME_START(fs), .TX_BYTE_VALID(bv), .TX_BYTE_CLASS(bcls),
    .TX_BYTE_IN(bin), .TX_BYTE_OUT_VALID(bov), .TX_BYTE_OUT(bout),
    .TX_POINTER(ptr), .TX_JUST_POS(jpos), .TX_JUST_NEG(jneg));
  line_stream_model u_line_stream_model (
    .clk(ref_clk), .frame_start(fs), .byte_valid(bv), .byte_class(bcls),
    .byte_in(bin), .byte_out(bout), .b3_valid(b3_v), .b3_mismatch(b3_m),
    .g1_valid(g1_v), .g1_far(g1_f));

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic wb(input logic w, input logic [6:0] idx,
                    input logic [7:0] wd, output logic [7:0] rd);
    @(posedge ref_clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    sel   <= 4'h1;
    adr   <= {23'h0, idx, 2'b00};
    dat_w <= {24'h0, wd};
    // this wait ends when ack goes high, else the bench timeout ends it
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] x;
    wb(1'b1, idx, d, x);
  endtask : wr
  task automatic rdc(input logic [6:0] idx, input logic [7:0] e);
    logic [7:0] x;
    wb(1'b0, idx, 8'h00, x);
    `CHK(x, e)
  endtask : rdc
  task automatic frame;
    u_line_stream_model.send_frame(g);
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(IDX_ARBITRARY_POINTER_VALUE_HI, ARBITRARY_POINTER_VALUE_HI_RESET);
    rdc(IDX_TX_PTR_CTL, 8'h00);
    rdc(IDX_TX_DIAG, 8'h00);
    wr(IDX_PARITY_CFG, 8'h20);
    rdc(IDX_PARITY_CFG, 8'h20);
    wr(IDX_PARITY_CFG, 8'h00);
    rdc(7'h7f, 8'h00);
  endtask : t_regs
  task automatic t_counts;
    logic [15:0] a, b;
    wr(IDX_PARITY_LO, 8'h00);
    wb(1'b0, IDX_EVENT_STATUS, 8'h00, a[7:0]);
    u_line_stream_model.rx(1'b1, 8'h03, 1'b1, 4'd5);
    `CHK({rep_v, rep}, 5'h12)
    u_line_stream_model.rx(1'b1, 8'h81, 1'b1, 4'd9);
    rdc(IDX_EVENT_STATUS, 8'h03);
    rdc(IDX_EVENT_STATUS, 8'h00);
    wr(IDX_FAR_HI, 8'h00);
    rdc(IDX_PARITY_LO, 8'h04);
    rdc(IDX_FAR_LO, 8'h05);
    rdc(IDX_FAR_HI, 8'h00);
    repeat (40) u_line_stream_model.rx(1'b1, 8'hff, 1'b0, 4'd0);
    fork
      wr(IDX_PARITY_HI, 8'h00);
      u_line_stream_model.rx(1'b1, 8'h01, 1'b0, 4'd0);
    join
    wb(1'b0, IDX_PARITY_LO, 8'h00, a[7:0]);
    wb(1'b0, IDX_PARITY_HI, 8'h00, a[15:8]);
    wr(IDX_PARITY_LO, 8'h00);
    wb(1'b0, IDX_PARITY_LO, 8'h00, b[7:0]);
    wb(1'b0, IDX_PARITY_HI, 8'h00, b[15:8]);
    `CHK(a[15:8], 8'h01)
    `CHK(a + b, 16'd321)
    wr(IDX_PARITY_CFG, 8'h20);
    u_line_stream_model.rx(1'b1, 8'hff, 1'b1, 4'd8);
    `CHK({rep_v, rep}, 5'h11)
    wr(IDX_MASTER, 8'h00);
    rdc(IDX_PARITY_LO, 8'h01);
    rdc(IDX_FAR_LO, 8'h08);
    wr(IDX_PARITY_CFG, 8'h00);
  endtask : t_counts
  task automatic t_diag;
    logic [7:0] ref_b3;
    frame();
    `CHK(g[39:16], 24'h600052)
    frame();
    ref_b3 = g[7:0];
    wr(IDX_TX_DIAG, 8'h02);
    frame();
    `CHK(g[7:0], ~ref_b3)
    wr(IDX_TX_DIAG, 8'h01);
    frame();
    `CHK(g[39:8], 32'hffffffff)
    wr(IDX_TX_DIAG, 8'h00);
    frame();
    `CHK(g[15:8], 8'h53)
  endtask : t_diag
  task automatic t_justify;
    wr(IDX_TX_PTR_CTL, 8'h02);
    frame();
    `CHK({jpos, g[39:24]}, 17'h162aa)
    rdc(IDX_TX_PTR_CTL, 8'h00);
    frame();
    `CHK({jpos, ptr}, 11'h001)
    wr(IDX_TX_PTR_CTL, 8'h04);
    frame();
    `CHK({jneg, g[39:24]}, 17'h16154)
    frame();
    `CHK({jneg, ptr}, 11'h000)
  endtask : t_justify
  task automatic t_spacing;
    // last negative step was two frames ago: held off two more frames
    wr(IDX_TX_PTR_CTL, 8'h22);
    for (int i = 0; i < 3; i++) begin
      frame();
      `CHK(jpos, (i == 2))
    end
    wr(IDX_TX_PTR_CTL, 8'h22);
    for (int i = 1; i < 5; i++) begin
      frame();
      `CHK(jpos, (i == 4))
    end
    wr(IDX_TX_PTR_CTL, 8'h00);
    frame();
    `CHK(ptr, 10'd2)
  endtask : t_spacing
  task automatic t_load;
    wr(IDX_ARBITRARY_POINTER_VALUE_LO, 8'h0e);
    wr(IDX_ARBITRARY_POINTER_VALUE_HI, 8'h03);
    wr(IDX_TX_PTR_CTL, 8'h10);
    frame();
    `CHK(ptr, PTR_MAX)
    rdc(IDX_TX_PTR_CTL, 8'h00);
    wr(IDX_ARBITRARY_POINTER_VALUE_LO, 8'h0f);
    wr(IDX_TX_PTR_CTL, 8'h10);
    frame();
    `CHK(ptr, PTR_MAX)
    rdc(IDX_TX_PTR_CTL, 8'h00);
    wr(IDX_ARBITRARY_POINTER_VALUE_HI, 8'ha3);
    wr(IDX_TX_PTR_CTL, 8'h08);
    frame();
    `CHK(g[39:24], 16'ha30e)
    wr(IDX_ARBITRARY_POINTER_VALUE_LO, 8'h55);
    wr(IDX_ARBITRARY_POINTER_VALUE_HI, 8'h01);
    wr(IDX_TX_PTR_CTL, 8'h40);
    frame();
    `CHK({ptr, g[33:24]}, {PTR_MAX, 10'h155})
    wr(IDX_TX_PTR_CTL, 8'h00);
    frame();
    `CHK(g[33:24], 10'h30e)
  endtask : t_load
  task automatic t_fixed;
    wr(IDX_MASTER, 8'h01);
    wr(IDX_TX_PTR_CTL, 8'h52);
    frame();
    frame();
    `CHK({jpos, ptr, g[33:24]}, {1'b0, PTR_MAX, 10'h30e})
    wr(IDX_MASTER, 8'h00);
  endtask : t_fixed
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    sel = 4'h1;
    dat_w = 32'h0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_counts();
    t_diag();
    t_justify();
    t_spacing();
    t_load();
    t_fixed();
    conclude();
  end
endmodule : tb
